/* File: hdl/telelink_pkg.sv */
// Shared constants and types for the telegram link
package telelink_pkg;
	localparam int CLK_HZ         = 20_000_000;
	localparam int BAUD_LOW       = 1200;
	localparam int BIT_CYC_LOW    = CLK_HZ / BAUD_LOW;
	localparam int CYCLE_MS_LOW   = 120;
	localparam int CYCLE_CYC_LOW  = CYCLE_MS_LOW * (CLK_HZ / 1000);
	localparam int PULSE_SHORT_MS = 40;
	localparam int PULSE_LONG_MS  = 500;
	localparam int PULSE_SHORT_CYC = PULSE_SHORT_MS * (CLK_HZ / 1000);
	localparam int PULSE_LONG_CYC  = PULSE_LONG_MS * (CLK_HZ / 1000);
	localparam int TIMER_W        = 24;
	localparam int TIMEOUT_SHIFT  = 2;
	localparam int TELEGRAM_BYTES = 6;
	localparam int BYTE_W         = 8;
	localparam int FIFO_DEPTH     = 32;
	localparam int SYNC_W         = 17;
	localparam logic [5:0] HEADER_TAG = 6'h29;
	localparam logic [1:0] EXT_NONE    = 2'h0;
	localparam logic [1:0] EXT_DIGITAL = 2'h1;
	localparam logic [1:0] EXT_ANALOG  = 2'h2;
	localparam logic [7:0] LINE_IDLE_BYTE = 8'hFF;

	typedef enum logic [1:0] {
		BAUD_1200 = 2'b00,
		BAUD_2400 = 2'b01,
		BAUD_4800 = 2'b10,
		BAUD_9600 = 2'b11
	} baud_type;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} rx_state_type;
endpackage

/* File: hdl/byte_stream_if.sv */
// Valid/ready byte stream between the telegram builder, FIFO and serializer
`timescale 1ns/1ps
interface byte_stream_if #(parameter int WIDTH = 8);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface

/* File: hdl/stream_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic       sys_clk,
	input wire logic       rst_b,
	byte_stream_if.sink    push,
	byte_stream_if.source  pop
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             full;
	logic             empty;

	// Extra pointer bit tells full from empty
	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign push.ready = !full;
	assign pop.valid  = !empty;
	assign pop.data   = mem[rd_ptr_reg[AW-1:0]];

	// Storage is not reset; only pointers carry state
	always_ff @(posedge sys_clk) begin
		if (push.valid && !full) begin
			mem[wr_ptr_reg[AW-1:0]] <= push.data;
		end
	end

	// Pointer update
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push.valid && !full) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop.ready && !empty) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule

/* File: hdl/telecontrol_telegram_link.sv */
// Transmitter and receiver logic of the one-way two-wire telegram link
`timescale 1ns/1ps
module telecontrol_telegram_link #(
	parameter int BIT_CYC         = telelink_pkg::BIT_CYC_LOW,
	parameter int CYCLE_CYC       = telelink_pkg::CYCLE_CYC_LOW,
	parameter int PULSE_SHORT_CYC = telelink_pkg::PULSE_SHORT_CYC,
	parameter int PULSE_LONG_CYC  = telelink_pkg::PULSE_LONG_CYC
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rst_b,
	input  wire telelink_pkg::baud_type baud_sel,
	input  wire logic                   count_input_first,
	input  wire logic                   count_input_second,
	input  wire logic [5:0]             base_in_upper,
	input  wire logic [7:0]             ext_in,
	input  wire logic [7:0]             analog_in,
	input  wire logic [1:0]             ext_mode,
	input  wire logic [1:0]             tx_count_mode,
	output logic                        line_tx,
	input  wire logic                   line_rx,
	input  wire logic [1:0]             rx_count_mode,
	input  wire logic                   pulse_long,
	input  wire logic                   fail_zero,
	output logic                        count_output_first,
	output logic                        count_output_second,
	output logic [5:0]                  base_out_upper,
	output logic [7:0]                  ext_out,
	output logic [7:0]                  analog_out,
	output logic                        link_fail
);
	localparam int TW = telelink_pkg::TIMER_W;
	localparam int NB = telelink_pkg::TELEGRAM_BYTES;

	logic [TW-1:0] bit_cyc;
	logic [TW-1:0] cycle_cyc;
	logic [TW-1:0] pulse_cyc;
	logic [telelink_pkg::SYNC_W-1:0] raw_in;
	logic [telelink_pkg::SYNC_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
	logic [1:0]    prev_reg;
	logic [7:0]    cnt_reg [2];
	logic [TW-1:0] poll_tmr_reg;
	logic [7:0]    tel_reg [NB];
	logic [7:0]    tel_next [NB];
	logic [2:0]    push_idx_reg;
	logic [9:0]    tx_shift_reg;
	logic [3:0]    tx_bit_reg;
	logic [TW-1:0] tx_tmr_reg;
	logic          tx_busy_reg;
	logic          line_tx_reg;
	telelink_pkg::rx_state_type rx_state_reg;
	logic [TW-1:0] rx_tmr_reg;
	logic [2:0]    rx_bit_reg;
	logic [7:0]    rx_shift_reg;
	logic          byte_stb_reg;
	logic [7:0]    rxf_reg [NB-1];
	logic [2:0]    asm_idx_reg;
	logic [7:0]    rx_sum;
	logic          valid_reg;
	logic          have_cnt_reg;
	logic [7:0]    last_cnt_reg [2];
	logic [7:0]    data_reg;
	logic [7:0]    ext_val_reg;
	logic [7:0]    analog_reg;
	logic [TW-1:0] to_tmr_reg;
	logic          link_fail_reg;
	logic [1:0]    pulse_reg;
	logic [7:0]    out_dig_reg;
	logic [7:0]    ext_out_reg;
	logic          rxd;

	byte_stream_if #(.WIDTH(telelink_pkg::BYTE_W)) push_if ();
	byte_stream_if #(.WIDTH(telelink_pkg::BYTE_W)) pop_if ();

	// Per-baud timings halve with each step of the selector
	assign bit_cyc   = TW'(BIT_CYC) >> baud_sel;
	assign cycle_cyc = TW'(CYCLE_CYC) >> baud_sel;
	assign pulse_cyc = pulse_long ? TW'(PULSE_LONG_CYC) : TW'(PULSE_SHORT_CYC);

	// Line, base, expansion and count inputs are three-stage synchronised and accepted when stages two and three agree
	assign raw_in = {line_rx, ext_in, base_in_upper, count_input_second, count_input_first};
	genvar gi;
	generate
		for (gi = 0; gi < telelink_pkg::SYNC_W; gi++) begin : g_sync
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					s1_reg[gi]   <= 1'b1;
					s2_reg[gi]   <= 1'b1;
					s3_reg[gi]   <= 1'b1;
					filt_reg[gi] <= 1'b1;
				end else begin
					s1_reg[gi] <= raw_in[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
					if (s2_reg[gi] == s3_reg[gi]) begin
						filt_reg[gi] <= s3_reg[gi];
					end
				end
			end
		end
	endgenerate
	assign rxd = filt_reg[16];

	// Rising edges accumulate into free-running counters; wrap is harmless at the receiver
	generate
		for (gi = 0; gi < 2; gi++) begin : g_txcnt
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					prev_reg[gi] <= 1'b1;
					cnt_reg[gi]  <= 8'h00;
				end else begin
					prev_reg[gi] <= filt_reg[gi];
					if (tx_count_mode[gi] && filt_reg[gi] && !prev_reg[gi]) begin
						cnt_reg[gi] <= cnt_reg[gi] + 8'h01;
					end
				end
			end
		end
	endgenerate

	// Telegram image: header, base, two counters, expansion byte, checksum
	always_comb begin
		tel_next[0] = {telelink_pkg::HEADER_TAG, ext_mode};
		tel_next[1] = filt_reg[7:0];
		tel_next[2] = cnt_reg[0];
		tel_next[3] = cnt_reg[1];
		unique case (ext_mode)
			telelink_pkg::EXT_DIGITAL: tel_next[4] = filt_reg[15:8];
			telelink_pkg::EXT_ANALOG:  tel_next[4] = analog_in;
			default:                   tel_next[4] = 8'h00;
		endcase
		tel_next[5] = tel_next[0] + tel_next[1] + tel_next[2] + tel_next[3] + tel_next[4];
	end

	// Poll timer snapshots the inputs and queues one telegram per cycle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			poll_tmr_reg <= '0;
			push_idx_reg <= 3'(NB);
			for (int i = 0; i < NB; i++) begin
				tel_reg[i] <= 8'h00;
			end
		end else begin
			if (poll_tmr_reg == '0) begin
				poll_tmr_reg <= cycle_cyc - 1'b1;
				if (push_idx_reg == 3'(NB)) begin
					tel_reg      <= tel_next;
					push_idx_reg <= 3'h0;
				end
			end else begin
				poll_tmr_reg <= poll_tmr_reg - 1'b1;
				if (push_idx_reg != 3'(NB) && push_if.ready) begin
					push_idx_reg <= push_idx_reg + 3'h1;
				end
			end
		end
	end
	assign push_if.valid = (push_idx_reg != 3'(NB)) && (poll_tmr_reg != '0);
	assign push_if.data  = (push_idx_reg < 3'(NB)) ? tel_reg[push_idx_reg] : 8'h00;

	stream_fifo #(
		.WIDTH(telelink_pkg::BYTE_W),
		.DEPTH(telelink_pkg::FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst_b  (rst_b),
		.push   (push_if.sink),
		.pop    (pop_if.source)
	);

	// Serializer stalls the FIFO while a character is on the line
	assign pop_if.ready = !tx_busy_reg;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_busy_reg  <= 1'b0;
			tx_shift_reg <= 10'h3FF;
			tx_bit_reg   <= 4'h0;
			tx_tmr_reg   <= '0;
			line_tx_reg  <= 1'b1;
		end else if (!tx_busy_reg) begin
			if (pop_if.valid) begin
				tx_busy_reg  <= 1'b1;
				tx_shift_reg <= {1'b1, pop_if.data, 1'b0};
				tx_bit_reg   <= 4'h0;
				tx_tmr_reg   <= bit_cyc - 1'b1;
				line_tx_reg  <= 1'b0;
			end
		end else if (tx_tmr_reg != '0) begin
			tx_tmr_reg <= tx_tmr_reg - 1'b1;
		end else if (tx_bit_reg == 4'h9) begin
			tx_busy_reg <= 1'b0;
		end else begin
			tx_bit_reg   <= tx_bit_reg + 4'h1;
			tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
			line_tx_reg  <= tx_shift_reg[1];
			tx_tmr_reg   <= bit_cyc - 1'b1;
		end
	end

	// Receive character: start bit checked at mid-bit, data sampled mid-bit, stop must be high
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_state_reg <= telelink_pkg::RX_IDLE;
			rx_tmr_reg   <= '0;
			rx_bit_reg   <= 3'h0;
			rx_shift_reg <= 8'h00;
			byte_stb_reg <= 1'b0;
		end else begin
			byte_stb_reg <= 1'b0;
			if (rx_state_reg != telelink_pkg::RX_IDLE && rx_tmr_reg != '0) begin
				rx_tmr_reg <= rx_tmr_reg - 1'b1;
			end else begin
				unique case (rx_state_reg)
					telelink_pkg::RX_IDLE: if (!rxd) begin
						rx_state_reg <= telelink_pkg::RX_START;
						rx_tmr_reg   <= bit_cyc >> 1;
					end
					telelink_pkg::RX_START: begin
						rx_state_reg <= rxd ? telelink_pkg::RX_IDLE : telelink_pkg::RX_DATA;
						rx_tmr_reg   <= bit_cyc - 1'b1;
						rx_bit_reg   <= 3'h0;
					end
					telelink_pkg::RX_DATA: begin
						rx_shift_reg <= {rxd, rx_shift_reg[7:1]};
						rx_bit_reg   <= rx_bit_reg + 3'h1;
						rx_tmr_reg   <= bit_cyc - 1'b1;
						if (rx_bit_reg == 3'h7) begin
							rx_state_reg <= telelink_pkg::RX_STOP;
						end
					end
					telelink_pkg::RX_STOP: begin
						rx_state_reg <= telelink_pkg::RX_IDLE;
						byte_stb_reg <= rxd;
					end
				endcase
			end
		end
	end

	// Telegram assembly hunts for the header, then checks the checksum on the last byte
	assign rx_sum = rxf_reg[0] + rxf_reg[1] + rxf_reg[2] + rxf_reg[3] + rxf_reg[4];
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			asm_idx_reg <= 3'h0;
			valid_reg   <= 1'b0;
			for (int i = 0; i < NB - 1; i++) begin
				rxf_reg[i] <= 8'h00;
			end
		end else begin
			valid_reg <= 1'b0;
			if (byte_stb_reg) begin
				if (asm_idx_reg == 3'(NB - 1)) begin
					valid_reg   <= (rx_sum == rx_shift_reg);
					asm_idx_reg <= 3'h0;
				end else if (asm_idx_reg != 3'h0 || rx_shift_reg[7:2] == telelink_pkg::HEADER_TAG) begin
					rxf_reg[asm_idx_reg] <= rx_shift_reg;
					asm_idx_reg          <= asm_idx_reg + 3'h1;
				end
			end
		end
	end

	// Only a checked telegram updates the held values
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			data_reg     <= 8'h00;
			ext_val_reg  <= 8'h00;
			analog_reg   <= 8'h00;
			have_cnt_reg <= 1'b0;
			last_cnt_reg <= '{8'h00, 8'h00};
		end else if (valid_reg) begin
			data_reg     <= rxf_reg[1];
			have_cnt_reg <= 1'b1;
			last_cnt_reg <= '{rxf_reg[2], rxf_reg[3]};
			if (rxf_reg[0][1:0] == telelink_pkg::EXT_DIGITAL) begin
				ext_val_reg <= rxf_reg[4];
			end
			if (rxf_reg[0][1:0] == telelink_pkg::EXT_ANALOG) begin
				analog_reg <= rxf_reg[4];
			end
		end
	end

	// Count differences queue up and leave as equal pulse and pause
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pulse
			logic [15:0]   pend_reg;
			logic [TW-1:0] ph_tmr_reg;
			logic [15:0]   add;
			logic          take;
			assign add  = (valid_reg && have_cnt_reg && rx_count_mode[gi]) ?
				16'(8'(rxf_reg[2 + gi] - last_cnt_reg[gi])) : 16'h0000;
			assign take = (ph_tmr_reg == '0) && !pulse_reg[gi] && (pend_reg != 16'h0000);
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					pend_reg      <= 16'h0000;
					ph_tmr_reg    <= '0;
					pulse_reg[gi] <= 1'b0;
				end else begin
					pend_reg <= pend_reg + add - {15'h0000, take};
					if (ph_tmr_reg != '0) begin
						ph_tmr_reg <= ph_tmr_reg - 1'b1;
					end else if (pulse_reg[gi] || take) begin
						pulse_reg[gi] <= !pulse_reg[gi];
						ph_tmr_reg    <= pulse_cyc - 1'b1;
					end
				end
			end
		end
	endgenerate

	// Missing several telegram periods declares the link disturbed
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			to_tmr_reg    <= '0;
			link_fail_reg <= 1'b1;
		end else if (valid_reg) begin
			to_tmr_reg    <= cycle_cyc << telelink_pkg::TIMEOUT_SHIFT;
			link_fail_reg <= 1'b0;
		end else if (to_tmr_reg != '0) begin
			to_tmr_reg <= to_tmr_reg - 1'b1;
		end else begin
			link_fail_reg <= 1'b1;
		end
	end

	// Output stage; analog output ignores the failure state on purpose
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_dig_reg <= 8'h00;
			ext_out_reg <= 8'h00;
		end else if (link_fail_reg && fail_zero) begin
			out_dig_reg <= 8'h00;
			ext_out_reg <= 8'h00;
		end else begin
			out_dig_reg[7:2] <= data_reg[7:2];
			out_dig_reg[1]   <= rx_count_mode[1] ? pulse_reg[1] : data_reg[1];
			out_dig_reg[0]   <= rx_count_mode[0] ? pulse_reg[0] : data_reg[0];
			ext_out_reg      <= ext_val_reg;
		end
	end

	assign line_tx             = line_tx_reg;
	assign count_output_first  = out_dig_reg[0];
	assign count_output_second = out_dig_reg[1];
	assign base_out_upper      = out_dig_reg[7:2];
	assign ext_out             = ext_out_reg;
	assign analog_out          = analog_reg;
	assign link_fail           = link_fail_reg;
endmodule

/* File: sim/telelink_chk.sv */
// Port checker for the telegram link, bound into the design top
`timescale 1ns/1ps
module telelink_chk #(
	parameter int BIT_CYC         = 16,
	parameter int CYCLE_CYC       = 2000,
	parameter int PULSE_SHORT_CYC = 20,
	parameter int PULSE_LONG_CYC  = 50
) (
	input wire logic                   sys_clk,
	input wire logic                   rst_b,
	input wire telelink_pkg::baud_type baud_sel,
	input wire logic                   line_tx,
	input wire logic                   line_rx,
	input wire logic [1:0]             rx_count_mode,
	input wire logic                   pulse_long,
	input wire logic                   fail_zero,
	input wire logic                   count_output_first,
	input wire logic [5:0]             base_out_upper,
	input wire logic [7:0]             ext_out,
	input wire logic [7:0]             analog_out,
	input wire logic                   link_fail
);
	int   lo_cnt;
	int   hi_cnt;
	int   quiet_cnt;
	logic fail_d;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Run lengths of line and pulse output, and quiet time since the link last recovered
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			lo_cnt <= 0;
			hi_cnt <= 0;
			quiet_cnt <= 0;
			fail_d <= 1'b1;
		end else begin
			lo_cnt <= line_tx ? 0 : lo_cnt + 1;
			hi_cnt <= count_output_first ? hi_cnt + 1 : 0;
			quiet_cnt <= (fail_d && !link_fail) ? 0 : quiet_cnt + 1;
			fail_d <= link_fail;
		end
	end
	tx_lowrun_a: assert property ($rose(line_tx) |->
		lo_cnt % (BIT_CYC >> baud_sel) == 0 && lo_cnt <= 9 * (BIT_CYC >> baud_sel))
		else $error("line low run is not a whole number of bits");
	analog_keep_a: assert property ($changed(analog_out) |-> !link_fail)
		else $error("analog output moved while link failed");
	fail_zero_a: assert property (link_fail && fail_zero |=> !link_fail ||
		(base_out_upper == 6'h00 && ext_out == 8'h00 && !count_output_first))
		else $error("outputs not forced low on link failure");
	fail_hold_a: assert property ((link_fail && !fail_zero) ##1 (link_fail && !fail_zero)
		|-> $stable(base_out_upper) && $stable(ext_out))
		else $error("outputs not held on link failure");
	fail_timeout_a: assert property ($rose(link_fail) |->
		quiet_cnt >= ((CYCLE_CYC >> baud_sel) << 2) - 8)
		else $error("link failure raised too early");
	rx_stop_a: assert property ($fell(link_fail) |-> $past(line_rx, 2))
		else $error("telegram accepted without a stop level");
	pulse_width_a: assert property ($fell(count_output_first) && rx_count_mode[0] |->
		hi_cnt == (pulse_long ? PULSE_LONG_CYC : PULSE_SHORT_CYC))
		else $error("count pulse width wrong");
	pulse_gap_a: assert property ($fell(count_output_first) && rx_count_mode[0] |=>
		!count_output_first [*8])
		else $error("count pulse pause too short");
	recover_c: cover property ($fell(link_fail));
	pulse_c: cover property ($rose(count_output_first) && rx_count_mode[0]);
	zeroed_c: cover property (link_fail && fail_zero);
endmodule

bind telecontrol_telegram_link telelink_chk #(
	.BIT_CYC(BIT_CYC), .CYCLE_CYC(CYCLE_CYC),
	.PULSE_SHORT_CYC(PULSE_SHORT_CYC), .PULSE_LONG_CYC(PULSE_LONG_CYC)
) u_chk (
	.sys_clk(sys_clk), .rst_b(rst_b), .baud_sel(baud_sel), .line_tx(line_tx),
	.line_rx(line_rx), .rx_count_mode(rx_count_mode), .pulse_long(pulse_long),
	.fail_zero(fail_zero), .count_output_first(count_output_first),
	.base_out_upper(base_out_upper), .ext_out(ext_out), .analog_out(analog_out),
	.link_fail(link_fail)
);

/* File: sim/far_end.sv */
// Far-end line model: sends telegrams on line_rx, decodes telegrams from line_tx
`timescale 1ns/1ps
module far_end #(
	parameter int BIT_CYC = 16
) (
	input wire logic sys_clk,
	output logic     line_rx,
	input wire logic line_tx
);
	logic [7:0] got [6];
	// Line idles high between characters
	initial line_rx = 1'b1;
	// One 8N1 character, LSB first, each bit held a full bit time
	task automatic put_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge sys_clk);
			line_rx <= fr[i];
			repeat (BIT_CYC - 1) @(posedge sys_clk);
		end
	endtask
	// Whole telegram; bad flips bit 0 of the checksum so the receiver must drop it
	task automatic send(input logic [1:0] md, input logic [7:0] i, c1, c2, x, input logic bad);
		logic [7:0] t [6];
		t = '{{telelink_pkg::HEADER_TAG, md}, i, c1, c2, x, 8'h00};
		t[5] = 8'(t[0] + t[1] + t[2] + t[3] + t[4]) ^ {7'h00, bad};
		for (int k = 0; k < 6; k++) put_byte(t[k]);
	endtask
	// Twelve idle bits can only be a gap between telegrams
	task automatic wait_idle(input int b);
		int h;
		h = 0;
		while (h < 12 * b) begin
			@(posedge sys_clk);
			h = line_tx ? h + 1 : 0;
		end
	endtask
	// Decode the next whole telegram, sampling mid-bit
	task automatic grab();
		wait_idle(BIT_CYC);
		for (int k = 0; k < 6; k++) begin
			@(negedge line_tx);
			repeat (BIT_CYC + BIT_CYC / 2) @(posedge sys_clk);
			for (int j = 0; j < 8; j++) begin
				got[k][j] = line_tx;
				repeat (BIT_CYC) @(posedge sys_clk);
			end
		end
	endtask
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the telegram link against the far-end model
`timescale 1ns/1ps
module tb_top;
	localparam int BIT = 16;
	localparam int CYC = 2000;
	logic                   sys_clk, rst_b, count_input_first, count_input_second;
	telelink_pkg::baud_type baud_sel;
	logic [5:0]             base_in_upper, base_out_upper;
	logic [7:0]             ext_in, analog_in, ext_out, analog_out;
	logic [1:0]             ext_mode, tx_count_mode, rx_count_mode;
	logic                   line_tx, line_rx, pulse_long, fail_zero;
	logic                   count_output_first, count_output_second, link_fail;
	int                     n_fail, checked, rises1, rises2;

	telecontrol_telegram_link #(.BIT_CYC(BIT), .CYCLE_CYC(CYC),
		.PULSE_SHORT_CYC(20), .PULSE_LONG_CYC(50)) dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .baud_sel(baud_sel),
		.count_input_first(count_input_first), .count_input_second(count_input_second),
		.base_in_upper(base_in_upper), .ext_in(ext_in), .analog_in(analog_in),
		.ext_mode(ext_mode), .tx_count_mode(tx_count_mode), .line_tx(line_tx),
		.line_rx(line_rx), .rx_count_mode(rx_count_mode), .pulse_long(pulse_long),
		.fail_zero(fail_zero), .count_output_first(count_output_first),
		.count_output_second(count_output_second), .base_out_upper(base_out_upper),
		.ext_out(ext_out), .analog_out(analog_out), .link_fail(link_fail));
	far_end #(.BIT_CYC(BIT)) u_far (.sys_clk(sys_clk), .line_rx(line_rx), .line_tx(line_tx));

	// Free-running 20 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// Replayed pulses are counted by their rising edges
	always @(posedge count_output_first) rises1++;
	always @(posedge count_output_second) rises2++;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Baud is only changed under reset, so no character is cut in half
	task automatic do_reset(input int s);
		@(negedge sys_clk);
		rst_b = 1'b0;
		baud_sel = telelink_pkg::baud_type'(s);
		repeat (12) @(negedge sys_clk);
		rst_b = 1'b1;
	endtask
	// Telegram spacing at every baud, measured start bit to start bit
	task automatic rate_test();
		realtime t0;
		for (int s = 3; s >= 0; s--) begin
			do_reset(s);
			u_far.wait_idle(BIT >> s);
			@(negedge line_tx);
			t0 = $realtime;
			u_far.wait_idle(BIT >> s);
			@(negedge line_tx);
			check("period", ($realtime - t0) / 50, CYC >> s);
		end
	endtask
	// Telegram content per expansion mode, with pulses counted between polls
	task automatic tx_test();
		logic [7:0] prev;
		for (int m = 0; m < 3; m++) begin
			@(negedge sys_clk);
			ext_mode = m[1:0];
			u_far.grab();
			check("header", u_far.got[0], {telelink_pkg::HEADER_TAG, m[1:0]});
			check("inputs", u_far.got[1], 8'hB6);
			if (m > 0) check("counter", u_far.got[2], 8'(prev + m));
			check("static_counter", u_far.got[3], 8'h00);
			check("expansion", u_far.got[4], m == 1 ? ext_in : m == 2 ? analog_in : 8'h00);
			check("sum", u_far.got[5], 8'(u_far.got[0] + u_far.got[1] + u_far.got[2]
				+ u_far.got[3] + u_far.got[4]));
			prev = u_far.got[2];
			// Phases kept long enough for the input filter
			for (int k = 0; k <= m; k++) begin
				repeat (10) @(negedge sys_clk);
				count_input_first = 1'b1;
				repeat (10) @(negedge sys_clk);
				count_input_first = 1'b0;
			end
		end
	endtask
	task automatic rx_outs(input logic [5:0] b, input logic [7:0] e, a, input logic f);
		repeat (3) @(negedge sys_clk);
		check("base_out", base_out_upper, b);
		check("ext_out", ext_out, e);
		check("analog_out", analog_out, a);
		check("link_fail", link_fail, f);
	endtask
	// Valid, corrupted and analog telegrams, counting, timeout and recovery
	task automatic rx_test();
		int r1, r2;
		u_far.send(2'h1, 8'hB4, 8'h07, 8'hFF, 8'h3C, 1'b0);
		rx_outs(6'h2D, 8'h3C, 8'h00, 1'b0);
		u_far.send(2'h1, 8'h48, 8'h07, 8'hFF, 8'hC3, 1'b1);
		rx_outs(6'h2D, 8'h3C, 8'h00, 1'b0);
		u_far.send(2'h2, 8'hB4, 8'h07, 8'hFF, 8'h81, 1'b0);
		rx_outs(6'h2D, 8'h3C, 8'h81, 1'b0);
		rx_count_mode = 2'b01;
		r1 = rises1;
		r2 = rises2;
		u_far.send(2'h1, 8'hB4, 8'h0A, 8'hFF, 8'h3C, 1'b0);
		repeat (300) @(negedge sys_clk);
		check("pulses_first", rises1 - r1, 3);
		check("pulses_second", rises2 - r2, 0);
		pulse_long = 1'b1;
		rx_count_mode = 2'b11;
		r1 = rises1;
		u_far.send(2'h1, 8'hB4, 8'h0A, 8'h01, 8'h3C, 1'b0);
		repeat (300) @(negedge sys_clk);
		check("pulses_wrap", rises2 - r2, 2);
		check("pulses_none", rises1 - r1, 0);
		repeat (4 * CYC) @(negedge sys_clk);
		rx_outs(6'h2D, 8'h3C, 8'h81, 1'b1);
		fail_zero = 1'b1;
		rx_count_mode = 2'b00;
		rx_outs(6'h00, 8'h00, 8'h81, 1'b1);
		u_far.send(2'h1, 8'hFD, 8'h0A, 8'h01, 8'h3C, 1'b0);
		rx_outs(6'h3F, 8'h3C, 8'h81, 1'b0);
		check("static_first", count_output_first, 1'b1);
	endtask

	// Main sequence; every input has a value at time zero
	initial begin
		rst_b = 1'b0;
		baud_sel = telelink_pkg::BAUD_1200;
		count_input_first = 1'b0;
		count_input_second = 1'b1;
		base_in_upper = 6'h2D;
		ext_in = 8'hA5;
		analog_in = 8'h5C;
		ext_mode = 2'h0;
		tx_count_mode = 2'b01;
		rx_count_mode = 2'b00;
		pulse_long = 1'b0;
		fail_zero = 1'b0;
		rate_test();
		tx_test();
		rx_test();
		end_of_test();
	end
	// Watchdog well above the expected run of some 29000 cycles
	initial begin
		repeat (100000) @(posedge sys_clk);
		n_fail++;
		end_of_test();
	end
endmodule
